/* host_port_pkg.sv */
// Constants and types of the parallel host port
// Function
// [R1] Serial bit clock is 4.096 or 8.192 MHz
// [R2] Non-multiplexed: low shared pins are address 0-2
// [R3] Non-multiplexed: next pins are address 3-5
// [R4] Wide configuration: low pins are serial 8-10
// [R5] Wide configuration: upper pins are serial 11-13
// [R6] Strobe styles: high strobe with chip select; with separate strobes the code accesses on a low read or write strobe instead
// [R7] Separate strobes: low read drives data lines
// [R8] Strobe styles: direction pin picks read or write; with separate strobes the code takes a read from a low strobe pin instead
// [R9] Separate strobes: low write takes data lines in
// [R10] Access only while chip select is low
// [R11] Data lines reach registers and memories
// [R12] Multiplexed: address comes from data lines
// [R13] Mode input high selects multiplexed bus
// [R14] Address latched on falling address strobe
// [R15] Acknowledge low marks each completed transfer
// [R16] Data lines released unless selected read
package host_port_pkg;
  localparam int SERIAL_CLK_LO_KHZ = 4096;
  localparam int SERIAL_CLK_HI_KHZ = 8192;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SYNC_W = 19;
  localparam int POS_CS = 0;
  localparam int POS_STB = 1;
  localparam int POS_DIR = 2;
  localparam int POS_ALS = 3;
  localparam int POS_IM = 4;
  localparam int POS_ADDR = 5;
  localparam int POS_DATA = 11;
  localparam logic [SYNC_W-1:0] SYNC_RST = 19'h00007;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [5:0] SERIAL_RST = 6'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD_WAIT = 2'b01,
    ST_ACK = 2'b10
  } port_state_t;

  function automatic logic [SYNC_W-1:0] settle(input logic [SYNC_W-1:0] s2, input logic [SYNC_W-1:0] s3,
                                               input logic [SYNC_W-1:0] old);
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & old);
  endfunction : settle
endpackage : host_port_pkg

/* cpu_host_port.sv */
// Parallel host port with shared address and serial pins
`timescale 1ns/100ps
module cpu_host_port (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic chip_select_n_in,
  input wire logic host_strobe_pin_in,
  input wire logic host_dir_pin_in,
  input wire logic address_latch_strobe_in,
  input wire logic bus_style_select_in,
  input wire logic separate_strobe_style_in,
  input wire logic wide_config_in,
  input wire logic [2:0] low_addr_or_extra_serial_in,
  input wire logic [2:0] upper_extra_serial_in,
  input wire logic [host_port_pkg::DATA_W-1:0] host_data_lines_in,
  output logic [host_port_pkg::DATA_W-1:0] host_data_lines_out,
  output logic host_data_lines_oe_out,
  output logic transfer_ack_n_out,
  output logic transfer_ack_oe_out,
  output logic [host_port_pkg::ADDR_W-1:0] reg_addr_out,
  output logic [host_port_pkg::DATA_W-1:0] reg_wr_data_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [host_port_pkg::DATA_W-1:0] reg_rd_data_in,
  output logic [5:0] extra_serial_out
);
  import host_port_pkg::*;

  logic [SYNC_W-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [SYNC_W-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_flt;
  logic [SYNC_W-1:0] pins;

  assign pins = {host_data_lines_in, upper_extra_serial_in, low_addr_or_extra_serial_in, bus_style_select_in,
                 address_latch_strobe_in, host_dir_pin_in, host_strobe_pin_in, chip_select_n_in};

  // Change accepted once second and third stage agree
  always_comb begin
    nxt_s1 = pins;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_flt = settle(s2_ff, s3_ff, flt_ff);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      s3_ff <= SYNC_RST;
      flt_ff <= SYNC_RST;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      flt_ff <= nxt_flt;
    end
  end

  logic cs_n, stb, dir, als, mux_mode, sep_mode;
  logic [5:0] addr_pins;
  logic [DATA_W-1:0] data_pins;
  logic access, is_read;
  logic [ADDR_W-1:0] cur_addr;

  assign cs_n = flt_ff[POS_CS];
  assign stb = flt_ff[POS_STB];
  assign dir = flt_ff[POS_DIR];
  assign als = flt_ff[POS_ALS];
  assign mux_mode = flt_ff[POS_IM]; // [R13]
  assign addr_pins = flt_ff[POS_ADDR +: 6];
  assign data_pins = flt_ff[POS_DATA +: DATA_W];
  // Separate read and write strobes only exist on the multiplexed bus
  assign sep_mode = mux_mode & separate_strobe_style_in;

  always_comb begin
    if (sep_mode) begin
      access = !cs_n && (!stb || !dir); // [R10] [R7] [R9]
      is_read = !stb; // [R7]
    end else begin
      access = !cs_n && stb; // [R6] [R10]
      is_read = dir; // [R8]
    end
  end

  logic als_prev_ff, nxt_als_prev;
  logic [ADDR_W-1:0] latch_ff, nxt_latch;
  logic [5:0] serial_ff, nxt_serial;

  always_comb begin
    nxt_als_prev = als;
    nxt_latch = latch_ff;
    if (mux_mode && als_prev_ff && !als) begin
      nxt_latch = data_pins; // [R12] [R14]
    end
    nxt_serial = wide_config_in ? addr_pins : SERIAL_RST; // [R4] [R5]
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      als_prev_ff <= 1'b0;
      latch_ff <= ADDR_RST;
      serial_ff <= SERIAL_RST;
    end else begin
      als_prev_ff <= nxt_als_prev;
      latch_ff <= nxt_latch;
      serial_ff <= nxt_serial;
    end
  end

  // Pins carry address only on the non-multiplexed bus
  assign cur_addr = mux_mode ? latch_ff : {2'b00, addr_pins}; // [R2] [R3] [R12]
  assign extra_serial_out = serial_ff;

  port_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd;

  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (access) begin // [R10]
          nxt_addr = cur_addr;
          if (is_read) begin
            nxt_rd = 1'b1; // [R11]
            nxt_state = ST_RD_WAIT;
          end else begin
            nxt_wdata = data_pins; // [R9] [R11]
            nxt_wr = 1'b1;
            nxt_state = ST_ACK;
          end
        end
      end
      ST_RD_WAIT: begin
        nxt_rdata = reg_rd_data_in; // [R11]
        nxt_state = ST_ACK;
      end
      ST_ACK: begin
        // One transfer per strobe; the host must end it before the next
        if (!access) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= ST_IDLE;
      addr_ff <= ADDR_RST;
      wdata_ff <= DATA_RST;
      rdata_ff <= DATA_RST;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  assign reg_addr_out = addr_ff;
  assign reg_wr_data_out = wdata_ff;
  assign reg_wr_out = wr_ff;
  assign reg_rd_out = rd_ff;
  assign host_data_lines_out = rdata_ff;
  assign host_data_lines_oe_out = access && is_read; // [R7] [R16]
  // Open drain: only ever pulls low
  assign transfer_ack_oe_out = (state_ff == ST_ACK); // [R15]
  assign transfer_ack_n_out = 1'b0;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  a_access_needs_cs: assert property ((reg_wr_out || reg_rd_out) |-> $past(!cs_n)) // [R10]
    else $error("Register access without chip select");
  a_oe_only_read: assert property (host_data_lines_oe_out |-> (!cs_n && is_read)) // [R16]
    else $error("Data lines driven outside a selected read");
  a_ack_timing: assert property ((state_ff == ST_IDLE && access) |-> ##[1:2] transfer_ack_oe_out) // [R15]
    else $error("Acknowledge late after access");
  a_sep_rd_drive: assert property ((sep_mode && !cs_n && !stb) |-> host_data_lines_oe_out) // [R7]
    else $error("Read strobe did not drive data lines");
  a_sep_wr_input: assert property ((sep_mode && stb && !dir) |-> !host_data_lines_oe_out) // [R9]
    else $error("Data lines driven during write strobe");
  a_strobe_gates: assert property ((!sep_mode && !stb) |-> !host_data_lines_oe_out) // [R6]
    else $error("Access without high data strobe");
  a_dir_selects: assert property ((state_ff == ST_IDLE && access && !sep_mode) |=> (reg_rd_out == $past(dir))) // [R8]
    else $error("Direction pin did not select transfer");
  a_mux_latch: assert property ((mux_mode && als_prev_ff && !als) |=> (latch_ff == $past(data_pins))) // [R12] [R14]
    else $error("Address not latched on strobe fall");
  a_nonmux_addr: assert property ((!mux_mode && state_ff == ST_IDLE && access) |=> // [R2] [R3] [R13]
    reg_addr_out == {2'b00, $past(addr_pins)})
    else $error("Address pins not used as address");
  a_extra_serial: assert property (wide_config_in |=> extra_serial_out == $past(addr_pins)) // [R4] [R5]
    else $error("Extra serial inputs not passed");
  a_rd_data: assert property (reg_rd_out |=> host_data_lines_out == $past(reg_rd_data_in)) // [R11]
    else $error("Read data not returned");

  c_write: cover property (reg_wr_out ##1 transfer_ack_oe_out);
  c_read: cover property (reg_rd_out ##1 transfer_ack_oe_out ##1 host_data_lines_oe_out);
  c_mux_latch: cover property (mux_mode && als_prev_ff && !als);
  c_sep_read: cover property (sep_mode && reg_rd_out);
endmodule : cpu_host_port

/* host_cpu_model.sv */
// Host processor model driving the parallel port pins
`timescale 1ns/100ps
module host_cpu_model (
  input wire logic core_clk_in,
  input wire logic ack_n_in,
  input wire logic [7:0] ad_in,
  output logic cs_n_out = 1'b1,
  output logic stb_out = 1'b0,
  output logic dir_out = 1'b1,
  output logic als_out = 1'b0,
  output logic [5:0] a_out = 6'h00,
  output logic [7:0] ad_out = 8'h00,
  output logic ad_oe_out = 1'b0
);
  task automatic access(input logic en, input logic mux, input logic sep, input logic rd,
                        input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
    int n;
    @(posedge core_clk_in);
    // Wrong pin address in mux mode, so only the latch can supply it
    a_out <= mux ? ~adr[5:0] : adr[5:0];
    ad_out <= mux ? adr : wd;
    ad_oe_out <= mux | ~rd;
    als_out <= mux;
    stb_out <= sep;
    repeat (6) @(posedge core_clk_in);
    als_out <= 1'b0;
    // Address held past the strobe fall, like a real host's hold time
    repeat (3) @(posedge core_clk_in);
    ad_out <= wd;
    ad_oe_out <= ~rd;
    repeat (3) @(posedge core_clk_in);
    cs_n_out <= ~en;
    stb_out <= sep ? ~rd : 1'b1;
    dir_out <= rd;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge core_clk_in);
      ok = (ack_n_in === 1'b0);
    end
    rdat = ad_in;
    cs_n_out <= 1'b1;
    stb_out <= sep;
    dir_out <= 1'b1;
    ad_oe_out <= 1'b0;
    repeat (8) @(posedge core_clk_in);
  endtask : access
  task automatic put_serial(input logic [5:0] v);
    @(posedge core_clk_in);
    a_out <= v;
    // Held two bits of the low serial rate: two periods of the slower bit clock
    repeat (2 * 50000 / host_port_pkg::SERIAL_CLK_LO_KHZ) @(posedge core_clk_in);
  endtask : put_serial
endmodule : host_cpu_model

/* tb_cpu_host_port.sv */
// Testbench for the parallel host port
`timescale 1ns/100ps
module tb_cpu_host_port;
  import host_port_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic bus_style = 1'b0;
  logic sep_style = 1'b0;
  logic wide = 1'b0;
  logic cs_n, stb, dir, als, h_oe, d_oe, ack_v, ack_oe, wr, rd, ok;
  logic [5:0] a, ser;
  logic [7:0] h_ad, d_ad, raddr, rwd, rdat, lwa, lwd;
  logic [7:0] mem [64];
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  logic [7:0] last_ad = 8'h00;
  // Pull-up on acknowledge; floating data lines show the inverse of the last driven byte
  wire logic ack_n = ack_oe ? ack_v : 1'b1;
  wire logic [7:0] ad = d_oe ? d_ad : h_oe ? h_ad : ~last_ad;
  wire logic [7:0] rdd = mem[raddr[5:0]];
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  always @(posedge core_clk_in) begin
    if (d_oe || h_oe) begin
      last_ad <= ad;
    end
    if (rd === 1'b1) begin
      rd_cnt++;
    end
    if (wr === 1'b1) begin
      mem[raddr[5:0]] <= rwd;
      lwa <= raddr;
      lwd <= rwd;
      wr_cnt++;
    end
  end
  cpu_host_port i_cpu_host_port (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .chip_select_n_in(cs_n),
    .host_strobe_pin_in(stb), .host_dir_pin_in(dir), .address_latch_strobe_in(als),
    .bus_style_select_in(bus_style), .separate_strobe_style_in(sep_style), .wide_config_in(wide),
    .low_addr_or_extra_serial_in(a[2:0]), .upper_extra_serial_in(a[5:3]), .host_data_lines_in(ad),
    .host_data_lines_out(d_ad), .host_data_lines_oe_out(d_oe), .transfer_ack_n_out(ack_v),
    .transfer_ack_oe_out(ack_oe), .reg_addr_out(raddr), .reg_wr_data_out(rwd), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_rd_data_in(rdd), .extra_serial_out(ser));
  host_cpu_model i_host_cpu_model (.core_clk_in(core_clk_in), .ack_n_in(ack_n), .ad_in(ad), .cs_n_out(cs_n),
    .stb_out(stb), .dir_out(dir), .als_out(als), .a_out(a), .ad_out(h_ad), .ad_oe_out(h_oe));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Write then read back one byte in the bus style set by mux and sep
  task automatic wr_rd(input logic mux, input logic sep, input logic [7:0] adr, input logic [7:0] wd);
    int n0;
    int n1;
    @(posedge core_clk_in);
    bus_style <= mux;
    sep_style <= sep;
    n0 = wr_cnt;
    i_host_cpu_model.access(1'b1, mux, sep, 1'b0, adr, wd, rdat, ok);
    chk("wr ack", 8'h01, {7'h00, ok});
    chk("wr pulses", 8'h01, 8'(wr_cnt - n0));
    chk("wr addr", mux ? adr : {2'b00, adr[5:0]}, lwa);
    chk("wr data", wd, lwd);
    n1 = rd_cnt;
    i_host_cpu_model.access(1'b1, mux, sep, 1'b1, adr, 8'h00, rdat, ok);
    chk("rd ack", 8'h01, {7'h00, ok});
    chk("rd pulses", 8'h01, 8'(rd_cnt - n1));
    chk("rd data", wd, rdat);
    chk("bus free", 8'h00, {7'h00, d_oe});
  endtask : wr_rd
  task automatic t_plain();
    wr_rd(1'b0, 1'b0, 8'h2D, 8'h5A);
  endtask : t_plain
  task automatic t_mux();
    wr_rd(1'b1, 1'b0, 8'hD3, 8'hC3);
  endtask : t_mux
  task automatic t_sep();
    wr_rd(1'b1, 1'b1, 8'h21, 8'h96);
  endtask : t_sep
  task automatic t_nocs();
    int n0;
    n0 = wr_cnt;
    i_host_cpu_model.access(1'b0, 1'b1, 1'b1, 1'b0, 8'h05, 8'hFF, rdat, ok);
    chk("no cs ack", 8'h00, {7'h00, ok});
    chk("no cs wr", 8'h00, 8'(wr_cnt - n0));
  endtask : t_nocs
  task automatic t_wide();
    @(posedge core_clk_in);
    wide <= 1'b1;
    i_host_cpu_model.put_serial(6'h2B);
    repeat (8) @(posedge core_clk_in);
    chk("serial", 8'h2B, {2'b00, ser});
    wide <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    chk("serial off", 8'h00, {2'b00, ser});
  endtask : t_wide
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    t_plain();
    t_mux();
    t_sep();
    t_nocs();
    t_wide();
    end_of_test();
  end
endmodule : tb_cpu_host_port
